/* File: design/gpdr_pkg.sv */
// package: register map, widths and reset values for the port data registers
package gpdr_pkg;

  localparam int unsigned GPDR_AW = 12;

  // byte offsets of the registers
  localparam logic [11:0] GPDR_OFF_B_PINS      = 12'h000;
  localparam logic [11:0] GPDR_OFF_C_UPPER     = 12'h004;
  localparam logic [11:0] GPDR_OFF_C_LOWER     = 12'h008;
  localparam logic [11:0] GPDR_OFF_D_PINS      = 12'h00c;
  localparam logic [11:0] GPDR_OFF_E_UPPER     = 12'h010;
  localparam logic [11:0] GPDR_OFF_E_LOWER     = 12'h014;
  localparam logic [11:0] GPDR_OFF_B_DIR       = 12'h020;
  localparam logic [11:0] GPDR_OFF_C_UPPER_DIR = 12'h024;
  localparam logic [11:0] GPDR_OFF_C_LOWER_DIR = 12'h028;
  localparam logic [11:0] GPDR_OFF_D_DIR       = 12'h02c;
  localparam logic [11:0] GPDR_OFF_E_UPPER_DIR = 12'h030;
  localparam logic [11:0] GPDR_OFF_E_LOWER_DIR = 12'h034;
  localparam logic [11:0] GPDR_OFF_ALT_SEL     = 12'h040;

  // pins per port
  localparam int unsigned GPDR_B_PINS = 14;
  localparam int unsigned GPDR_C_PINS = 21;
  localparam int unsigned GPDR_D_PINS = 8;
  localparam int unsigned GPDR_E_PINS = 25;
  localparam int unsigned GPDR_ALL_PINS = 68;

  // bit position of each port within the flat pin vector
  localparam int unsigned GPDR_B_POS = 0;
  localparam int unsigned GPDR_C_POS = 14;
  localparam int unsigned GPDR_D_POS = 35;
  localparam int unsigned GPDR_E_POS = 43;

  // valid-bit masks of the six 16-bit registers
  localparam logic [15:0] GPDR_MASK_B  = 16'h3fff;
  localparam logic [15:0] GPDR_MASK_CU = 16'h001f;
  localparam logic [15:0] GPDR_MASK_CL = 16'hffff;
  localparam logic [15:0] GPDR_MASK_D  = 16'h00ff;
  localparam logic [15:0] GPDR_MASK_EU = 16'h01ff;
  localparam logic [15:0] GPDR_MASK_EL = 16'hffff;

  localparam logic [67:0] GPDR_RST_DATA = 68'h0;
  localparam logic [67:0] GPDR_RST_DIR  = 68'h0;
  localparam logic [67:0] GPDR_RST_ALT  = 68'h0;

  // glitch length after a watchdog power-on reset, in pclk periods
  localparam int unsigned GPDR_GLITCH_CYC = 1;

  typedef enum logic [1:0] {
    GPDR_RS_IDLE  = 2'b00,
    GPDR_RS_GLTCH = 2'b01,
    GPDR_RS_RUN   = 2'b11
  } gpdr_rst_st_t;

endpackage

/* File: design/gpdr_port.sv */
// general-purpose port data registers for ports b, c, d and e, apb slave
`timescale 1ns/1ps
//
// Contract
// RULE_01 - writing a data bit of an output-mode pin drives that value onto the pin at once.
// RULE_02 - reading a data bit of an output-mode pin returns the stored value, not the pin.
// RULE_03 - reading a data bit of an input-mode pin returns the sampled pin level.
// RULE_04 - writing a data bit of an input-mode pin updates storage only, the pin is untouched.
// RULE_05 - the port b register is 16 bits with bits 13..0 for pins 13..0.
// RULE_06 - port c uses an upper register (bits 4..0 = pins 20..16) and a lower one (pins 15..0).
// RULE_07 - the port d register is 16 bits with bits 7..0 for pins 7..0.
// RULE_08 - port e uses an upper register (bits 8..0 = pins 24..16) and a lower one (pins 15..0).
// RULE_09 - after a watchdog power-on reset each alternate-output pin acts as a general output for one pclk, driving its data bit.
// RULE_10 - a power-on reset from the external reset pin gives no such one-cycle behaviour.
// RULE_11 - software sets data bits of strobe pins to the strobe's inactive level.
// RULE_12 - a direction bit of 1 makes the pin an output, 0 an input.
// RULE_13 - every data bit resets to 0 on power-on reset.
// RULE_14 - unmapped data bit positions read as zero and ignore writes.
module gpdr_port
  import gpdr_pkg::*;
(
  // apb
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [gpdr_pkg::GPDR_AW-1:0]   paddr,
  input  wire logic [31:0]                    pwdata,
  input  wire logic [3:0]                     pstrb,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // reset cause, level valid while presetn is low
  input  wire logic                           wdt_reset_cause,
  // alternate functions
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] alt_out,
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] alt_oe,
  // pins
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_in,
  output logic      [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_out,
  output logic      [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_oe
);
  import gpdr_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // register index: 0..5 data, 8..13 direction, 16 alt select
  function automatic logic [4:0] reg_idx(input logic [GPDR_AW-1:0] a);
    reg_idx = a[6:2];
  endfunction

  function automatic logic [15:0] reg_mask(input logic [2:0] i);
    case (i)
      3'h0:    reg_mask = GPDR_MASK_B;
      3'h1:    reg_mask = GPDR_MASK_CU;
      3'h2:    reg_mask = GPDR_MASK_CL;
      3'h3:    reg_mask = GPDR_MASK_D;
      3'h4:    reg_mask = GPDR_MASK_EU;
      3'h5:    reg_mask = GPDR_MASK_EL;
      default: reg_mask = 16'h0000;
    endcase
  endfunction

  // flat-vector position of bit 0 of each register
  function automatic int unsigned reg_pos(input logic [2:0] i);
    case (i)
      3'h0:    reg_pos = GPDR_B_POS;
      3'h1:    reg_pos = GPDR_C_POS + 16;
      3'h2:    reg_pos = GPDR_C_POS;
      3'h3:    reg_pos = GPDR_D_POS;
      3'h4:    reg_pos = GPDR_E_POS + 16;
      default: reg_pos = GPDR_E_POS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic [GPDR_ALL_PINS-1:0] pin_sync;

  gpdr_sync #(.W(GPDR_ALL_PINS)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  // ----------------------------------------------------------------
  // storage and bus
  // ----------------------------------------------------------------
  logic [GPDR_ALL_PINS-1:0] data_q, data_d;
  logic [GPDR_ALL_PINS-1:0] dir_q, dir_d;
  logic [GPDR_ALL_PINS-1:0] alt_q, alt_d;
  logic [31:0]              prdata_q, prdata_d;
  logic                     pready_q, pready_d;
  logic                     pslverr_q, pslverr_d;

  logic                     acc;
  logic [4:0]               idx;
  logic                     is_data, is_dir, is_alt;
  logic [15:0]              wmask;
  logic [15:0]              rmask;
  int unsigned              pos;

  assign acc     = psel && !penable;
  assign idx     = reg_idx(paddr);
  assign is_data = (idx < 5'd6) && (paddr[1:0] == 2'b00) && (paddr[GPDR_AW-1:7] == '0);
  assign is_dir  = (idx >= 5'd8) && (idx < 5'd14) && (paddr[1:0] == 2'b00)
                   && (paddr[GPDR_AW-1:7] == '0);
  assign is_alt  = (paddr == GPDR_OFF_ALT_SEL);

  always_comb begin
    data_d    = data_q;
    dir_d     = dir_q;
    alt_d     = alt_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    rmask     = reg_mask(idx[2:0]);
    wmask     = rmask & {{8{pstrb[1]}}, {8{pstrb[0]}}};
    pos       = reg_pos(idx[2:0]);
    // no wait state: answer lands in the cycle after setup
    if (acc) begin
      pready_d  = 1'b1;
      pslverr_d = !(is_data || is_dir || is_alt);
      prdata_d  = 32'h0000_0000;
      if (is_data || is_dir) begin
        for (int b = 0; b < 16; b++) begin
          if (rmask[b]) begin
            if (is_dir) begin
              prdata_d[b] = dir_q[pos+b];
              if (pwrite && wmask[b]) dir_d[pos+b] = pwdata[b];              // see RULE_12
            end else begin
              // output reads the latch, input reads the pin
              prdata_d[b] = dir_q[pos+b] ? data_q[pos+b] : pin_sync[pos+b]; // see RULE_02 RULE_03
              if (pwrite && wmask[b]) data_d[pos+b] = pwdata[b];             // see RULE_04
            end
          end
        end
        // bits outside the mask stay zero on read and are never written: see RULE_14
        // see RULE_05 RULE_06 RULE_07 RULE_08
      end else if (is_alt) begin
        prdata_d = 32'h0000_0000;
      end
    end
    if (acc && is_alt && pwrite) begin
      // alt select: writes are accepted but ignored, alt_q keeps its reset value and reads return zero
      alt_d = alt_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q    <= GPDR_RST_DATA;   // see RULE_13
      dir_q     <= GPDR_RST_DIR;
      alt_q     <= GPDR_RST_ALT;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      data_q    <= data_d;
      dir_q     <= dir_d;
      alt_q     <= alt_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // reset-cause sequencer
  // ----------------------------------------------------------------
  // the cause runs through a two-flop synchroniser that is never reset, and is read on the first edge after release
  gpdr_rst_st_t rst_st_q, rst_st_d;
  logic         wdt_cause_sync;
  logic         glitch;

  gpdr_sync #(.W(1)) u_cause_sync (
    .pclk     (pclk),
    .presetn  (1'b1),
    .async_in (wdt_reset_cause),
    .sync_out (wdt_cause_sync)
  );

  always_comb begin
    rst_st_d = rst_st_q;
    case (rst_st_q)
      GPDR_RS_IDLE:  rst_st_d = wdt_cause_sync ? GPDR_RS_GLTCH : GPDR_RS_RUN; // see RULE_10
      GPDR_RS_GLTCH: rst_st_d = GPDR_RS_RUN;                                  // see RULE_09
      GPDR_RS_RUN:   rst_st_d = GPDR_RS_RUN;
      default:       rst_st_d = GPDR_RS_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_st_q <= GPDR_RS_IDLE;
    end else begin
      rst_st_q <= rst_st_d;
    end
  end

  assign glitch = (rst_st_q == GPDR_RS_GLTCH);

  // ----------------------------------------------------------------
  // pin drive, registered
  // ----------------------------------------------------------------
  logic [GPDR_ALL_PINS-1:0] out_q, out_d, oe_q, oe_d;

  always_comb begin
    out_d = out_q;
    oe_d  = oe_q;
    for (int p = 0; p < GPDR_ALL_PINS; p++) begin
      if (alt_oe[p] && !glitch) begin
        out_d[p] = alt_out[p];
        oe_d[p]  = 1'b1;
      end else if (alt_oe[p]) begin
        out_d[p] = data_d[p];           // see RULE_09
        oe_d[p]  = 1'b1;
      end else begin
        // data_d so the pin follows in the same edge as the write
        out_d[p] = data_d[p];           // see RULE_01
        oe_d[p]  = dir_d[p];            // see RULE_12 RULE_04
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      oe_q  <= '0;
    end else begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe  = oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_write_drives;
    @(posedge pclk) disable iff (!presetn)
      (acc && pwrite && is_data && idx == 5'd0 && pstrb[0] && dir_q[0] && !alt_oe[0])
      |=> (pin_out[0] == $past(pwdata[0]) && pin_oe[0]);
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("write not driven"); // see RULE_01

  property p_out_readback;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && idx == 5'd3 && is_data && dir_q[GPDR_D_POS])
      |=> (prdata[0] == data_q[GPDR_D_POS]);
  endproperty
  a_out_readback: assert property (p_out_readback) else $error("bad latch read"); // see RULE_02

  property p_in_read;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && idx == 5'd2 && is_data && !dir_q[GPDR_C_POS])
      |=> (prdata[0] == $past(pin_sync[GPDR_C_POS]));
  endproperty
  a_in_read: assert property (p_in_read) else $error("bad pin read"); // see RULE_03

  property p_in_no_drive;
    @(posedge pclk) disable iff (!presetn)
      (!dir_q[GPDR_E_POS] && !alt_oe[GPDR_E_POS] && !dir_d[GPDR_E_POS])
      |=> !pin_oe[GPDR_E_POS];
  endproperty
  a_in_no_drive: assert property (p_in_no_drive) else $error("input pin driven"); // see RULE_04

  property p_unmapped_zero;
    @(posedge pclk) disable iff (!presetn)
      (acc && is_data && idx == 5'd1) |=> (prdata[31:5] == '0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped bit set"); // see RULE_14

  property p_glitch_once;
    @(posedge pclk) disable iff (!presetn)
      glitch |=> !glitch;
  endproperty
  a_glitch_once: assert property (p_glitch_once) else $error("glitch too long"); // see RULE_09

  property p_no_glitch_ext;
    @(posedge pclk) disable iff (!presetn)
      (rst_st_q == GPDR_RS_IDLE && !wdt_cause_sync) |=> !glitch;
  endproperty
  a_no_glitch_ext: assert property (p_no_glitch_ext) else $error("glitch on pin reset"); // see RULE_10

  property p_ready_one;
    @(posedge pclk) disable iff (!presetn)
      acc |=> pready ##1 !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready timing"); // pready high for one cycle after setup

  c_glitch:  cover property (@(posedge pclk) disable iff (!presetn) glitch);
  c_wr_out:  cover property (@(posedge pclk) disable iff (!presetn) acc && pwrite && is_data);
  c_rd_in:   cover property (@(posedge pclk) disable iff (!presetn) acc && !pwrite && is_data);
  c_err:     cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

/* File: design/gpdr_sync.sv */
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
module gpdr_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

/* File: verification/gpdr_board.sv */
// board model: external signals on the port pins
`timescale 1ns/1ps
module gpdr_board
  import gpdr_pkg::*;
(
  // device side
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_out,
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_oe,
  // levels the board drives on undriven pins
  input  wire logic [gpdr_pkg::GPDR_ALL_PINS-1:0] ext_level,
  // level seen at the pins
  output logic      [gpdr_pkg::GPDR_ALL_PINS-1:0] pin_in
);
  // a driven pin reads back its own drive; the board never fights the device
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

/* File: verification/tb.sv */
// testbench: port data registers over apb against a board model
`timescale 1ns/1ps
module tb;
  import gpdr_pkg::*;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [GPDR_AW-1:0]     paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic [3:0]             pstrb;
  logic                   pready;
  logic                   pslverr;
  logic                   wdt_reset_cause;
  logic [GPDR_ALL_PINS-1:0] alt_out;
  logic [GPDR_ALL_PINS-1:0] alt_oe;
  logic [GPDR_ALL_PINS-1:0] pin_in;
  logic [GPDR_ALL_PINS-1:0] pin_out;
  logic [GPDR_ALL_PINS-1:0] pin_oe;
  logic [GPDR_ALL_PINS-1:0] ext_level;
  int                     n_mismatch;
  int                     checks_done;
  logic [11:0] doff [6] = '{GPDR_OFF_B_PINS, GPDR_OFF_C_UPPER, GPDR_OFF_C_LOWER,
                            GPDR_OFF_D_PINS, GPDR_OFF_E_UPPER, GPDR_OFF_E_LOWER};
  logic [15:0] msk  [6] = '{GPDR_MASK_B, GPDR_MASK_CU, GPDR_MASK_CL,
                            GPDR_MASK_D, GPDR_MASK_EU, GPDR_MASK_EL};
  int          pos  [6] = '{0, 30, 14, 35, 59, 43};

  // ----------------------------------------
  // instances
  // ----------------------------------------
  gpdr_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wdt_reset_cause(wdt_reset_cause),
    .alt_out(alt_out), .alt_oe(alt_oe), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe));
  gpdr_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] slice(input logic [67:0] v, input int i);
    return 16'(v >> pos[i]) & msk[i];
  endfunction

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [67:0] seen, input logic [67:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; starts after an edge so release and next setup never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic        err;
    apb(1'b1, a, {16'h0, d}, q, err);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [31:0] q;
    logic        err;
    apb(1'b0, a, 32'h0, q, err);
    chk({36'h0, q}, {52'h0, e});
  endtask

  // reset with a chosen cause, count cycles where alternate outputs show data bits
  task automatic rst_run(input logic cause, input int exp_n);
    int n;
    @(posedge pclk);
    alt_out <= '1; // strobes idle high, data bits low: glitch visible
    alt_oe <= '1;
    wdt_reset_cause <= cause;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    repeat (10) begin
      @(posedge pclk);
      #1;
      if (pin_oe === '1 && pin_out === '0) n++;
    end
    chk(68'(n), 68'(exp_n));
    @(posedge pclk);
    alt_oe <= '0;
    wdt_reset_cause <= 1'b0;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] v;
    logic [31:0] q;
    logic        err;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h3;
    wdt_reset_cause = 1'b0;
    alt_out = '0;
    alt_oe = '0;
    ext_level = '0;
    void'($urandom(56));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(doff[i] + 12'h020, 16'hffff);
      rd(doff[i], 16'h0);
    end
    for (int r = 0; r < 5; r++) begin
      for (int i = 0; i < 6; i++) begin
        // first round drives every bit, unmapped ones included
        v = (r == 0) ? 16'hffff : 16'($urandom);
        wr(doff[i] + 12'h020, 16'hffff);
        wr(doff[i], v);
        #1;
        chk(68'(slice(pin_out, i)), 68'(v & msk[i]));
        chk(68'(slice(pin_oe, i)), 68'(msk[i]));
        rd(doff[i], v & msk[i]);
        ext_level <= 68'({$urandom, $urandom, $urandom});
        wr(doff[i] + 12'h020, 16'h0);
        #1;
        chk(68'(slice(pin_oe, i)), 68'h0);
        repeat (3) @(posedge pclk);
        rd(doff[i], slice(ext_level, i));
        wr(doff[i], ~v);
        #1;
        chk(68'(slice(pin_oe, i)), 68'h0);
        wr(doff[i] + 12'h020, 16'hffff);
        #1;
        chk(68'(slice(pin_out, i)), 68'(~v & msk[i]));
      end
    end
    // low byte lane only: the high byte keeps what it held
    wr(doff[2], 16'h1234);
    pstrb <= 4'h1;
    wr(doff[2], 16'hab56);
    pstrb <= 4'h3;
    rd(doff[2], 16'h1256);
    apb(1'b1, 12'h0fc, 32'hffff_ffff, q, err);
    chk(68'(err), 68'h1);
    apb(1'b0, 12'h0fc, 32'h0, q, err);
    chk({35'h0, q, err}, 68'h1);
    rst_run(1'b0, 0);
    rst_run(1'b1, GPDR_GLITCH_CYC);
    tally_and_finish();
  end
endmodule
